/* common/cispc_pkg.sv */
package cispc_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS        = 8'h04;
  localparam logic [7:0] ADDR_CONTROL       = 8'h08;

  // Field positions in the power control register.
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;

  // Field positions in the control register.
  localparam int LCD_EN_BIT = 0;
  localparam int WDT_EN_BIT = 1;

  // Field positions in the status register.
  localparam int ST_IDLE_BIT  = 0;
  localparam int ST_STOP_BIT  = 1;
  localparam int ST_WDT_BIT   = 2;
  localparam int ST_LCD_BIT   = 3;

  // Values after reset.
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [1:0] CONTROL_RESET       = 2'h3;

  // Reset vector handed to the core after any reset.
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Lost clock detector timeout.
  localparam int CLK_MHZ        = 50;
  localparam int LCD_TIMEOUT_US = 100;
  localparam int LCD_CYCLES     = LCD_TIMEOUT_US * CLK_MHZ;

  // Default watchdog timeout in cycles.
  localparam int WDT_CYCLES = 65536;

  // Length of the internal reset pulse in cycles.
  localparam int RESET_PULSE_CYCLES = 4;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    PM_RUN   = 2'b00,
    PM_IDLE  = 2'b01,
    PM_STOP  = 2'b10,
    PM_RESET = 2'b11
  } cispc_mode_t;

endpackage

/* src/cispc_top.sv */
`timescale 1ns/1ns

// Notes on behaviour
// - Two low-power states, idle and stop, each with its own select bit.
// - Idle halts only the CPU; clocks and peripherals keep running.
// - Stop halts CPU, system clock, interrupts and timers except lost clock detector.
// - Writing idle select finishes the instruction, then halts CPU in idle.
// - Idle keeps all registers and memory unchanged.
// - Idle ends only on enabled interrupt, reset pin, or reset.
// - Interrupt wake clears idle select in hardware and restarts execution.
// - After wake the pending interrupt is serviced, then execution continues after.
// - Reset ending idle runs normal reset sequence, fetch from address zero.
// - Watchdog keeps counting in idle; its timeout resets and ends idle.
// - Once oscillator is off, only reset resumes execution.
// - Writing stop select finishes the instruction, then stops CPU and oscillator.
// - Stop ends only by reset; normal sequence, start at address zero.
// - Enabled lost clock detector resets and ends stop; disable for long sleep.
module cispc_top
  import cispc_pkg::*;
#(
  parameter int WDT_TIMEOUT = WDT_CYCLES,
  parameter int LCD_TIMEOUT = LCD_CYCLES
)
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_EXT_RST_N,
  input  wire logic        I_IRQ_PENDING,
  input  wire logic        I_INSN_DONE,
  input  wire logic        I_WDT_KICK,
  input  wire logic        I_WDT_LOCK,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             O_CPU_HALT,
  output logic             O_SYSCLK_EN,
  output logic             O_PERIPH_CLK_EN,
  output logic             O_CORE_RST,
  output logic [15:0]      O_RESET_VECTOR,
  output logic             O_WAKE_IRQ
);

  localparam logic [31:0] WDT_LIMIT = 32'(WDT_TIMEOUT - 1);
  localparam logic [31:0] LCD_LIMIT = 32'(LCD_TIMEOUT - 1);
  localparam logic [2:0]  RST_LIMIT = 3'(RESET_PULSE_CYCLES - 1);

  cispc_mode_t mode_q, mode_d;
  logic [7:0]  power_control_register_q, power_control_register_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic        idle_req_q, idle_req_d;
  logic        stop_req_q, stop_req_d;
  logic [31:0] wdt_cnt_q, wdt_cnt_d;
  logic [31:0] lcd_cnt_q, lcd_cnt_d;
  logic [2:0]  rst_cnt_q, rst_cnt_d;
  logic        wdt_flag_q, wdt_flag_d;
  logic        lcd_flag_q, lcd_flag_d;
  logic        wake_q, wake_d;
  logic        aw_got_q, aw_got_d;
  logic        w_got_q, w_got_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_fire;
  logic        wdt_expire;
  logic        lcd_expire;
  logic        any_reset;

  assign S_AXI_AWREADY = !aw_got_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_got_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;

  assign wr_fire    = aw_got_q && w_got_q && !bvalid_q;
  // The watchdog runs in run and idle, since idle keeps the system and peripheral clocks alive.
  assign wdt_expire = ctrl_q[WDT_EN_BIT] && (mode_q != PM_STOP) && (mode_q != PM_RESET)
                      && (wdt_cnt_q == WDT_LIMIT);
  // The detector counts only while the system clock is halted.
  // A detector enabled late in a long stop fires at once rather than after a counter wrap.
  assign lcd_expire = ctrl_q[LCD_EN_BIT] && (mode_q == PM_STOP) && (lcd_cnt_q >= LCD_LIMIT);
  assign any_reset  = !I_EXT_RST_N || wdt_expire || lcd_expire;

  always_comb
  begin
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_got_d  = 1'b1;
      aw_addr_d = S_AXI_AWADDR[7:0];
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_got_d  = 1'b1;
      w_data_d = S_AXI_WDATA;
      w_strb_d = S_AXI_WSTRB;
    end
    if (wr_fire)
    begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = (aw_addr_q == ADDR_POWER_CONTROL || aw_addr_q == ADDR_CONTROL
                  || aw_addr_q == ADDR_STATUS) ? AXI_OKAY : AXI_SLVERR;
    end
    else if (bvalid_q && S_AXI_BREADY)
    begin
      bvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_d = 1'b1;
      rresp_d  = AXI_OKAY;
      unique case (S_AXI_ARADDR[7:0])
        ADDR_POWER_CONTROL: rdata_d = {24'h000000, power_control_register_q};
        ADDR_CONTROL:       rdata_d = {30'h00000000, ctrl_q};
        ADDR_STATUS:        rdata_d = {28'h0000000, lcd_flag_q, wdt_flag_q,
                                       mode_q == PM_STOP, mode_q == PM_IDLE};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = AXI_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && S_AXI_RREADY)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_comb
  begin
    mode_d     = mode_q;
    power_control_register_d     = power_control_register_q;
    ctrl_d     = ctrl_q;
    idle_req_d = idle_req_q;
    stop_req_d = stop_req_q;
    wdt_cnt_d  = wdt_cnt_q;
    lcd_cnt_d  = lcd_cnt_q;
    rst_cnt_d  = rst_cnt_q;
    wdt_flag_d = wdt_flag_q;
    lcd_flag_d = lcd_flag_q;
    wake_d     = 1'b0;
    if (wr_fire && aw_addr_q == ADDR_POWER_CONTROL && w_strb_q[0] && mode_q == PM_RUN)
    begin
      power_control_register_d[7:2] = w_data_q[7:2] & 6'h36;
      if (w_data_q[IDLE_BIT])
      begin
        power_control_register_d[IDLE_BIT] = 1'b1;
        idle_req_d       = 1'b1;
      end
      if (w_data_q[STOP_BIT])
      begin
        stop_req_d = 1'b1;
      end
    end
    if (wr_fire && aw_addr_q == ADDR_CONTROL && w_strb_q[0])
    begin
      ctrl_d[LCD_EN_BIT] = w_data_q[LCD_EN_BIT];
      // A locked watchdog cannot be switched off.
      ctrl_d[WDT_EN_BIT] = w_data_q[WDT_EN_BIT] | (I_WDT_LOCK & ctrl_q[WDT_EN_BIT]);
    end
    if (wr_fire && aw_addr_q == ADDR_STATUS && w_strb_q[0])
    begin
      wdt_flag_d = wdt_flag_q & ~w_data_q[ST_WDT_BIT];
      lcd_flag_d = lcd_flag_q & ~w_data_q[ST_LCD_BIT];
    end
    // The watchdog freezes with the system clock in stop and restarts from zero after any reset.
    if (I_WDT_KICK || !ctrl_q[WDT_EN_BIT] || wdt_expire || mode_q == PM_RESET)
    begin
      wdt_cnt_d = 32'h00000000;
    end
    else if (mode_q != PM_STOP)
    begin
      wdt_cnt_d = wdt_cnt_q + 32'h00000001;
    end
    lcd_cnt_d = (mode_q == PM_STOP) ? lcd_cnt_q + 32'h00000001 : 32'h00000000;
    if (wdt_expire)
    begin
      wdt_flag_d = 1'b1;
    end
    if (lcd_expire)
    begin
      lcd_flag_d = 1'b1;
    end
    if (any_reset)
    begin
      mode_d     = PM_RESET;
      rst_cnt_d  = 3'h0;
      power_control_register_d     = POWER_CONTROL_RESET;
      idle_req_d = 1'b0;
      stop_req_d = 1'b0;
    end
    else
    begin
      unique case (mode_q)
        PM_RUN:
        begin
          // Entry waits for the writing instruction to retire.
          if (stop_req_q && I_INSN_DONE)
          begin
            mode_d     = PM_STOP;
            stop_req_d = 1'b0;
            idle_req_d = 1'b0;
          end
          else if (idle_req_q && I_INSN_DONE)
          begin
            mode_d     = PM_IDLE;
            idle_req_d = 1'b0;
          end
        end
        PM_IDLE:
        begin
          if (I_IRQ_PENDING)
          begin
            mode_d           = PM_RUN;
            power_control_register_d[IDLE_BIT] = 1'b0;
            wake_d           = 1'b1;
          end
        end
        PM_STOP:
        begin
          mode_d = PM_STOP;
        end
        PM_RESET:
        begin
          rst_cnt_d = rst_cnt_q + 3'h1;
          if (rst_cnt_q == RST_LIMIT)
          begin
            mode_d = PM_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      mode_q     <= PM_RESET;
      power_control_register_q     <= POWER_CONTROL_RESET;
      ctrl_q     <= CONTROL_RESET;
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      wdt_cnt_q  <= 32'h00000000;
      lcd_cnt_q  <= 32'h00000000;
      rst_cnt_q  <= 3'h0;
      wdt_flag_q <= 1'b0;
      lcd_flag_q <= 1'b0;
      wake_q     <= 1'b0;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      aw_addr_q  <= 8'h00;
      w_data_q   <= 32'h00000000;
      w_strb_q   <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'h0;
      rvalid_q   <= 1'b0;
      rresp_q    <= 2'h0;
      rdata_q    <= 32'h00000000;
    end
    else
    begin
      mode_q     <= mode_d;
      power_control_register_q     <= power_control_register_d;
      ctrl_q     <= ctrl_d;
      idle_req_q <= idle_req_d;
      stop_req_q <= stop_req_d;
      wdt_cnt_q  <= wdt_cnt_d;
      lcd_cnt_q  <= lcd_cnt_d;
      rst_cnt_q  <= rst_cnt_d;
      wdt_flag_q <= wdt_flag_d;
      lcd_flag_q <= lcd_flag_d;
      wake_q     <= wake_d;
      aw_got_q   <= aw_got_d;
      w_got_q    <= w_got_d;
      aw_addr_q  <= aw_addr_d;
      w_data_q   <= w_data_d;
      w_strb_q   <= w_strb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
    end
  end

  // Halting only the CPU clock leaves core state frozen, not cleared.
  assign O_CPU_HALT      = (mode_q != PM_RUN);
  assign O_SYSCLK_EN     = (mode_q != PM_STOP);
  assign O_PERIPH_CLK_EN = (mode_q != PM_STOP);
  assign O_CORE_RST      = (mode_q == PM_RESET);
  assign O_RESET_VECTOR  = RESET_VECTOR;
  assign O_WAKE_IRQ      = wake_q;

endmodule // cispc_top

/* bench/cispc_checker.sv */
`timescale 1ns/1ns
module cispc_checker
(
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_EXT_RST_N,
  input wire logic        I_IRQ_PENDING,
  input wire logic        O_CPU_HALT,
  input wire logic        O_SYSCLK_EN,
  input wire logic        O_PERIPH_CLK_EN,
  input wire logic        O_CORE_RST,
  input wire logic [15:0] O_RESET_VECTOR,
  input wire logic        O_WAKE_IRQ
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence idle_irq;
    O_CPU_HALT && O_SYSCLK_EN && !O_CORE_RST && I_IRQ_PENDING && I_EXT_RST_N;
  endsequence
  sequence woken;
    !O_CPU_HALT ##[0:1] O_WAKE_IRQ;
  endsequence
  a_idle_wake: assert property (idle_irq |=> woken)
    else $error("no wake from idle");
  a_wake_once: assert property (O_WAKE_IRQ |=> !O_WAKE_IRQ)
    else $error("wake pulse too long");
  a_stop_halts: assert property (!O_SYSCLK_EN |-> O_CPU_HALT && !O_PERIPH_CLK_EN)
    else $error("stop left a part running");
  a_idle_clocks: assert property (O_SYSCLK_EN |-> O_PERIPH_CLK_EN)
    else $error("peripheral clock off");
  a_stop_exit: assert property ($rose(O_SYSCLK_EN) |-> O_CORE_RST)
    else $error("stop left without reset");
  a_ext_reset: assert property (!I_EXT_RST_N |-> ##[1:3] O_CORE_RST && O_CPU_HALT)
    else $error("pin reset ignored");
  a_rst_length: assert property ($fell(O_CORE_RST) |-> $past(O_CORE_RST, 4))
    else $error("reset sequence too short");
  a_rst_vector: assert property (O_CORE_RST |-> O_CPU_HALT && O_RESET_VECTOR == 16'h0000)
    else $error("bad reset state");
endmodule // cispc_checker

/* bench/cispc_cpu_model.sv */
`timescale 1ns/1ns
module cispc_cpu_model
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_halt,
  input  wire logic i_slow,
  input  wire logic i_irq_req,
  output logic      o_insn_done,
  output logic      o_irq_pending
);
  logic [1:0] beat_q;
  // A halted core retires nothing; a slow core retires one instruction in four cycles.
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      beat_q <= 2'h0;
      o_insn_done <= 1'b0;
      o_irq_pending <= 1'b0;
    end
    else
    begin
      beat_q <= beat_q + 2'h1;
      o_insn_done <= !i_halt && (!i_slow || beat_q == 2'h3);
      o_irq_pending <= i_irq_req;
    end
endmodule // cispc_cpu_model

/* bench/tb.sv */
`timescale 1ns/1ns
module tb;
  import cispc_pkg::*;
  localparam int WDT = 50;
  localparam int LCD = 20;
  logic clk = 1'b0, rst_n = 1'b0, ext_n = 1'b1, irq_req = 1'b0, slow = 1'b0, kick = 1'b0;
  logic lock = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, seed = 32'h0C59, rdata;
  logic awrdy, wrdy, bv, arrdy, rv, halt, clk_en, pclk_en, core_rst, wake, done, irq;
  logic [1:0] bresp, rresp;
  logic [15:0] vec;
  int bad_count = 0, comparisons = 0, cyc = 0, wakes = 0;
  cispc_top #(.WDT_TIMEOUT(WDT), .LCD_TIMEOUT(LCD)) i_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n),
    .I_EXT_RST_N(ext_n), .I_IRQ_PENDING(irq), .I_INSN_DONE(done), .I_WDT_KICK(kick), .I_WDT_LOCK(lock),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .O_CPU_HALT(halt), .O_SYSCLK_EN(clk_en), .O_PERIPH_CLK_EN(pclk_en), .O_CORE_RST(core_rst),
    .O_RESET_VECTOR(vec), .O_WAKE_IRQ(wake));
  cispc_cpu_model i_cpu (.i_clk(clk), .i_rst_n(rst_n), .i_halt(halt), .i_slow(slow),
    .i_irq_req(irq_req), .o_insn_done(done), .o_irq_pending(irq));
  always #10 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // A running core kicks the watchdog at random; a halted one cannot.
  always @(posedge clk)
  begin
    cyc++;
    kick <= (^rnd()) & !halt;
    if (wake === 1'b1)
      wakes++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awv, wv, bready} <= {24'h0, a, d, 3'h7};
    fork
      begin
        do @(negedge clk); while (awrdy !== 1'b1);
        @(posedge clk);
        awv <= 1'b0;
      end
      begin
        do @(negedge clk); while (wrdy !== 1'b1);
        @(posedge clk);
        wv <= 1'b0;
      end
    join
    do @(negedge clk); while (bv !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, AXI_OKAY});
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {araddr, arv, rready} <= {24'h0, a, 2'h3};
    do @(negedge clk); while (arrdy !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    check("rdata", rdata, exp);
    check("rresp", {30'h0, rresp}, {30'h0, (a == 8'h0C) ? AXI_SLVERR : AXI_OKAY});
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic wait_on(input int s, input logic v);
    for (int n = 0; n < 300 && (s ? core_rst : halt) !== v; n++)
      @(negedge clk);
  endtask
  task automatic ext_reset();
    @(posedge clk);
    ext_n <= 1'b0;
    irq_req <= 1'b0;
    @(posedge clk);
    ext_n <= 1'b1;
    wait_on(1, 1'b1);
    check("vector", {16'h0, vec}, 32'h0);
    wait_on(1, 1'b0);
    check("resumed", {31'h0, halt}, 32'h0);
  endtask
  initial
  begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, 32'h3);
    rd(8'h0C, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      r = rnd() & 32'hFC;
      slow <= r[2];
      wr(ADDR_POWER_CONTROL, r);
      rd(ADDR_POWER_CONTROL, r & 32'hD8);
    end
    wr(ADDR_POWER_CONTROL, 32'h1);
    wait_on(0, 1'b1);
    check("idle", {28'h0, halt, clk_en, pclk_en, core_rst}, 32'hE);
    rd(ADDR_STATUS, 32'h1);
    @(posedge clk);
    irq_req <= 1'b1;
    wait_on(0, 1'b0);
    @(posedge clk);
    irq_req <= 1'b0;
    rd(ADDR_POWER_CONTROL, 32'h0);
    check("wakes", 32'(wakes), 32'h1);
    wr(ADDR_POWER_CONTROL, 32'h1);
    wait_on(1, 1'b1);
    check("wdt reset", {31'h0, core_rst}, 32'h1);
    wait_on(1, 1'b0);
    rd(ADDR_STATUS, 32'h4);
    wr(ADDR_STATUS, 32'hC);
    rd(ADDR_STATUS, 32'h0);
    lock <= 1'b1;
    wr(ADDR_CONTROL, 32'h1);
    rd(ADDR_CONTROL, 32'h3);
    lock <= 1'b0;
    wr(ADDR_CONTROL, 32'h1);
    wr(ADDR_POWER_CONTROL, 32'h1);
    wait_on(0, 1'b1);
    repeat (3 * WDT) @(negedge clk);
    check("long idle", {30'h0, halt, core_rst}, 32'h2);
    ext_reset();
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_POWER_CONTROL, 32'h3);
    wait_on(0, 1'b1);
    @(posedge clk);
    irq_req <= 1'b1;
    repeat (3 * LCD) @(negedge clk);
    check("stop", {29'h0, halt, clk_en, pclk_en}, 32'h4);
    ext_reset();
    wr(ADDR_CONTROL, 32'h1);
    wr(ADDR_POWER_CONTROL, 32'h2);
    wait_on(0, 1'b1);
    wait_on(1, 1'b1);
    check("lcd reset", {31'h0, core_rst}, 32'h1);
    wait_on(1, 1'b0);
    rd(ADDR_STATUS, 32'h8);
    close_out();
  end
endmodule // tb
bind cispc_top cispc_checker i_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_EXT_RST_N(I_EXT_RST_N),
  .I_IRQ_PENDING(I_IRQ_PENDING), .O_CPU_HALT(O_CPU_HALT), .O_SYSCLK_EN(O_SYSCLK_EN),
  .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN), .O_CORE_RST(O_CORE_RST), .O_RESET_VECTOR(O_RESET_VECTOR),
  .O_WAKE_IRQ(O_WAKE_IRQ));
